// ---- clk_ctrl_defs.svh ----
// Offsets, field positions, reset values and counts of the clock control
`ifndef CLK_CTRL_DEFS_SVH
`define CLK_CTRL_DEFS_SVH

// Wishbone register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_GATES 8'h08

// Control register fields
`define CTRL_MODE_R 2:0
`define CTRL_SLEEP_B 3
`define CTRL_PLL_EN_B 4
`define CTRL_PRESC_R 11:8
`define CTRL_RESET 32'h0000_0000

// Status register fields
`define STAT_CKSEL_R 3:0
`define STAT_SUT_R 5:4
`define STAT_DIV8_B 6
`define STAT_LOCK_B 7
`define STAT_MULT_R 15:8
`define STAT_SRC_R 18:16
`define STAT_STATE_R 22:20

// Fuse levels: one is unprogrammed, zero is programmed
`define FUSE_PROG 1'b0
`define FUSE_UNPROG 1'b1
`define FUSE_CKSEL_DEF 4'hE
`define FUSE_SUT_DEF 2'h1
`define FUSE_DIV8_DEF 1'b0

// Source select codes
`define CKS_EXT 4'h0
`define CKS_RC 4'h2
`define CKS_LF_HI 3'h2

// Power-up time-out lengths in watchdog oscillator cycles
`define TOUT_NONE 16'h0000
`define TOUT_SHORT 16'h0200
`define TOUT_LONG 16'h2000

// Oscillator start-up lengths in oscillator cycles
`define SU_EXT 16'h0006
`define SU_258 16'h0102
`define SU_1K 16'h0400
`define SU_16K 16'h4000

// PLL
`define PLL_MULT 8'h18
`define PLL_LOCK_CYC 16'h0064

// System clock divider
`define DIV8_LAST 3'h7

`endif

// ---- clk_ctrl_pkg.sv ----
// Types shared by the clock source select and start-up control
package clk_ctrl_pkg;

  typedef struct packed {
    logic cpu;
    logic io;
    logic flash;
    logic adc;
    logic asy;
    logic usb;
  } gates_t;

  typedef enum logic [2:0] {
    SLP_IDLE,
    SLP_ADC_NR,
    SLP_PWR_DOWN,
    SLP_PWR_SAVE,
    SLP_STANDBY,
    SLP_EXT_STANDBY
  } sleep_mode_t;

  typedef enum logic [2:0] {
    SRC_LP_XTAL,
    SRC_LF_XTAL,
    SRC_RC,
    SRC_EXT,
    SRC_RESERVED
  } src_t;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_TIMEOUT,
    ST_STARTUP,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE
  } state_t;

endpackage

// ---- clock_source_select_startup.sv ----
// Clock source select, start-up reset sequencing and clock domain gating
//
// Notes on behaviour
// - Sleep mode stops the clocks of unused domains.
// - Core does nothing while its clock is stopped.
// - Some external interrupts are seen while the peripheral clock is off.
// - Two-wire slave address match works in every sleep mode.
// - Program memory clock runs together with the core clock.
// - Async timer clock comes from its own external source.
// - Async timer keeps counting in every sleep mode but power-down and standby.
// - Converter clock may run while core and peripheral clocks are off.
// - USB clock comes from a PLL multiplying its input by 24.
// - Four source fuses pick low power, low frequency, RC or external.
// - Fuse bit one means unprogrammed, zero means programmed.
// - Factory fuses: source 1110, start-up 01, divide-by-eight on.
// - Programmed divide fuse divides the selected source by eight.
// - Internal reset is held a time-out after other resets release.
// - Time-out counts watchdog cycles chosen by start-up and source fuses.
// - Time-out lengths are 0, 512 or 8192 watchdog cycles.
// - Ripple counter on the oscillator holds reset for start-up count.
// - From reset: time-out, then start-up count, then release.
// - Wake from power-save or power-down: start-up count only.
`timescale 1ns/1ps
`include "clk_ctrl_defs.svh"

// Three-flop filter: a level change counts once stages two and three agree
module pin_filter #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level <= (s2_q & ~(s2_q ^ s3_q)) | (level & (s2_q ^ s3_q));
    end
  end
endmodule // pin_filter

////////////////////////////////////////////////////////////////////////////
module clock_source_select_startup #(
  parameter int ADDR_W = 8,
  parameter logic [15:0] TOUT_LONG_CYC = `TOUT_LONG,
  parameter logic [15:0] SU_16K_CYC = `SU_16K,
  parameter logic [15:0] PLL_LOCK_CYC = `PLL_LOCK_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADDR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [3:0] FUSE_CKSEL,
  input wire logic [1:0] FUSE_SUT,
  input wire logic FUSE_DIV8,
  input wire logic RST_SRC_N,
  input wire logic WDT_OSC,
  input wire logic SEL_OSC,
  input wire logic EXT_INT,
  input wire logic TWI_ADDR_MATCH,
  output clk_ctrl_pkg::gates_t GATES,
  output logic INT_RESET_N,
  output logic SYS_TICK,
  output logic ASYNC_INT,
  output logic TWI_WAKE
);

  clk_ctrl_pkg::state_t state_q;
  clk_ctrl_pkg::src_t src;
  clk_ctrl_pkg::sleep_mode_t mode_q;
  clk_ctrl_pkg::gates_t gates_d;
  logic [4:0] lvl;
  logic [1:0] lvl_prev_q;
  logic wdt_edge;
  logic osc_edge;
  logic rst_src_ok;
  logic wake;
  logic [3:0] cksel_q;
  logic [1:0] sut_q;
  logic div8_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_nx;
  logic [15:0] tout;
  logic [15:0] su;
  logic [2:0] div_q;
  logic sleep_req_q;
  logic pll_en_q;
  logic [3:0] presc_q;
  logic [15:0] lock_q;
  logic pll_lock;
  logic bus_req;
  logic [31:0] rd_data;

  ////////////////////////////////////////////////////////////////////////
  // Pin inputs: oscillators, reset sources and wake pins

  pin_filter #(.W(5)) u_filter (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .pin({TWI_ADDR_MATCH, EXT_INT, RST_SRC_N, SEL_OSC, WDT_OSC}),
    .level(lvl)
  );

  assign rst_src_ok = lvl[2];
  assign wdt_edge = lvl[0] & ~lvl_prev_q[0];
  assign osc_edge = lvl[1] & ~lvl_prev_q[1];
  assign wake = lvl[3] | lvl[4];

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lvl_prev_q <= 2'h0;
    end else begin
      lvl_prev_q <= lvl[1:0];
    end
  end

  // Wake pins seen regardless of peripheral gating
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ASYNC_INT <= 1'b0;
      TWI_WAKE <= 1'b0;
    end else begin
      ASYNC_INT <= lvl[3];
      TWI_WAKE <= lvl[4];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fuses: static, so they are re-read while other resets are held

  // Factory values until the fuses are read
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cksel_q <= `FUSE_CKSEL_DEF;
      sut_q <= `FUSE_SUT_DEF;
      div8_q <= `FUSE_DIV8_DEF;
    end else if (state_q == clk_ctrl_pkg::ST_HOLD) begin
      cksel_q <= FUSE_CKSEL;
      sut_q <= FUSE_SUT;
      div8_q <= FUSE_DIV8;
    end
  end

  always_comb begin
    if (cksel_q[3]) begin
      src = clk_ctrl_pkg::SRC_LP_XTAL;
    end else if (cksel_q[3:1] == `CKS_LF_HI) begin
      src = clk_ctrl_pkg::SRC_LF_XTAL;
    end else if (cksel_q == `CKS_RC) begin
      src = clk_ctrl_pkg::SRC_RC;
    end else if (cksel_q == `CKS_EXT) begin
      src = clk_ctrl_pkg::SRC_EXT;
    end else begin
      src = clk_ctrl_pkg::SRC_RESERVED;
    end
  end

  // Time-out length from start-up and source fuses
  always_comb begin
    tout = `TOUT_NONE;
    su = `SU_EXT;
    case (src)
      clk_ctrl_pkg::SRC_LP_XTAL: begin
        case ({cksel_q[0], sut_q})
          3'h0, 3'h3, 3'h6: tout = `TOUT_SHORT;
          3'h1, 3'h4, 3'h7: tout = TOUT_LONG_CYC;
          default: tout = `TOUT_NONE;
        endcase
        if (cksel_q[0] && sut_q != 2'h0) begin
          su = SU_16K_CYC;
        end else if (!cksel_q[0] && !sut_q[1]) begin
          su = `SU_258;
        end else begin
          su = `SU_1K;
        end
      end
      clk_ctrl_pkg::SRC_LF_XTAL, clk_ctrl_pkg::SRC_RC,
      clk_ctrl_pkg::SRC_EXT: begin
        case (sut_q)
          2'h1: tout = `TOUT_SHORT;
          2'h2: tout = TOUT_LONG_CYC;
          default: tout = `TOUT_NONE;
        endcase
        su = (src == clk_ctrl_pkg::SRC_LF_XTAL) ? `SU_1K : `SU_EXT;
      end
      default: begin
        tout = TOUT_LONG_CYC;
        su = SU_16K_CYC;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset sequencer: time-out on watchdog edges, start-up on oscillator

  assign cnt_nx = cnt_q + 16'h0001;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= clk_ctrl_pkg::ST_HOLD;
      cnt_q <= 16'h0000;
    end else if (!rst_src_ok) begin
      // Any other reset source restarts the whole sequence
      state_q <= clk_ctrl_pkg::ST_HOLD;
      cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        clk_ctrl_pkg::ST_HOLD: begin
          cnt_q <= 16'h0000;
          // Time-out first, skipped when its length is zero
          state_q <= (tout == `TOUT_NONE) ? clk_ctrl_pkg::ST_STARTUP
                                          : clk_ctrl_pkg::ST_TIMEOUT;
        end
        clk_ctrl_pkg::ST_TIMEOUT: begin
          if (wdt_edge) begin
            if (cnt_nx >= tout) begin
              cnt_q <= 16'h0000;
              state_q <= clk_ctrl_pkg::ST_STARTUP;
            end else begin
              cnt_q <= cnt_nx;
            end
          end
        end
        clk_ctrl_pkg::ST_STARTUP, clk_ctrl_pkg::ST_WAKE: begin
          // Ripple count of the selected oscillator
          if (osc_edge) begin
            if (cnt_nx >= su) begin
              cnt_q <= 16'h0000;
              state_q <= clk_ctrl_pkg::ST_RUN;
            end else begin
              cnt_q <= cnt_nx;
            end
          end
        end
        clk_ctrl_pkg::ST_RUN: begin
          if (sleep_req_q) begin
            state_q <= clk_ctrl_pkg::ST_SLEEP;
          end
        end
        clk_ctrl_pkg::ST_SLEEP: begin
          // Deep modes redo start-up only, never the time-out
          if (wake) begin
            cnt_q <= 16'h0000;
            if (mode_q == clk_ctrl_pkg::SLP_PWR_DOWN ||
                mode_q == clk_ctrl_pkg::SLP_PWR_SAVE) begin
              state_q <= clk_ctrl_pkg::ST_WAKE;
            end else begin
              state_q <= clk_ctrl_pkg::ST_RUN;
            end
          end
        end
        default: state_q <= clk_ctrl_pkg::ST_HOLD;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      INT_RESET_N <= 1'b0;
    end else begin
      INT_RESET_N <= (state_q == clk_ctrl_pkg::ST_RUN) ||
                     (state_q == clk_ctrl_pkg::ST_SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Domain gating

  always_comb begin
    gates_d = '0;
    case (state_q)
      clk_ctrl_pkg::ST_RUN: begin
        gates_d = '1;
        gates_d.usb = pll_en_q & pll_lock;
      end
      clk_ctrl_pkg::ST_SLEEP: begin
        case (mode_q)
          clk_ctrl_pkg::SLP_IDLE: begin
            gates_d.io = 1'b1;
            gates_d.adc = 1'b1;
            gates_d.asy = 1'b1;
            gates_d.usb = pll_en_q & pll_lock;
          end
          // Converter and async timer run, core and peripheral clocks stop, for low noise
          clk_ctrl_pkg::SLP_ADC_NR: begin
            gates_d.adc = 1'b1;
            gates_d.asy = 1'b1;
          end
          // Real-time counter keeps its own clock
          clk_ctrl_pkg::SLP_PWR_SAVE, clk_ctrl_pkg::SLP_EXT_STANDBY: begin
            gates_d.asy = 1'b1;
          end
          default: gates_d = '0;
        endcase
      end
      // Reset phases keep all domains gated
      default: gates_d = '0;
    endcase
    // Program memory clock follows the core clock
    gates_d.flash = gates_d.cpu;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      GATES <= '0;
    end else begin
      GATES <= gates_d;
    end
  end

  // System tick: every oscillator edge, or every eighth one
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_q <= 3'h0;
      SYS_TICK <= 1'b0;
    end else begin
      // No tick reaches the core while its clock is stopped
      SYS_TICK <= osc_edge && GATES.cpu &&
                  (div8_q != `FUSE_PROG || div_q == `DIV8_LAST);
      if (osc_edge && GATES.cpu) begin
        div_q <= div_q + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PLL lock timer; the factor is fixed, software sets only the enable and the prescaler

  // Fixed multiply, lock after a settle time
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lock_q <= 16'h0000;
    end else if (!pll_en_q) begin
      lock_q <= 16'h0000;
    end else if (!pll_lock) begin
      lock_q <= lock_q + 16'h0001;
    end
  end

  assign pll_lock = (lock_q >= PLL_LOCK_CYC);

  ////////////////////////////////////////////////////////////////////////
  // Wishbone classic slave, one wait state, unmapped reads zero

  assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;

  always_comb begin
    rd_data = 32'h0000_0000;
    case (WB_ADR_I)
      `REG_CTRL: begin
        rd_data[`CTRL_MODE_R] = mode_q;
        rd_data[`CTRL_PLL_EN_B] = pll_en_q;
        // Prescaler read back as software wrote it
        rd_data[`CTRL_PRESC_R] = presc_q;
      end
      `REG_STATUS: begin
        // Raw fuse levels, zero meaning programmed
        rd_data[`STAT_CKSEL_R] = cksel_q;
        rd_data[`STAT_SUT_R] = sut_q;
        rd_data[`STAT_DIV8_B] = div8_q;
        rd_data[`STAT_LOCK_B] = pll_lock;
        rd_data[`STAT_MULT_R] = `PLL_MULT;
        rd_data[`STAT_SRC_R] = src;
        rd_data[`STAT_STATE_R] = state_q;
      end
      `REG_GATES: rd_data[5:0] = GATES;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= bus_req;
      WB_DAT_O <= bus_req ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_q <= clk_ctrl_pkg::SLP_IDLE;
      pll_en_q <= 1'b0;
      presc_q <= 4'h0;
      sleep_req_q <= 1'b0;
    end else begin
      // Sleep request is a one-cycle strobe, lost if not in run
      sleep_req_q <= 1'b0;
      if (bus_req && WB_WE_I && WB_ADR_I == `REG_CTRL) begin
        if (WB_SEL_I[0]) begin
          mode_q <= clk_ctrl_pkg::sleep_mode_t'(WB_DAT_I[`CTRL_MODE_R]);
          sleep_req_q <= WB_DAT_I[`CTRL_SLEEP_B];
          pll_en_q <= WB_DAT_I[`CTRL_PLL_EN_B];
        end
        if (WB_SEL_I[1]) begin
          presc_q <= WB_DAT_I[`CTRL_PRESC_R];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  sequence go_sleep_s;
    state_q == clk_ctrl_pkg::ST_RUN ##1 state_q == clk_ctrl_pkg::ST_SLEEP;
  endsequence

  sequence deep_wake_s;
    state_q == clk_ctrl_pkg::ST_SLEEP ##1 state_q == clk_ctrl_pkg::ST_WAKE;
  endsequence

  sleep_stops_cpu_a: assert property (
    go_sleep_s |=> !GATES.cpu) else $error("cpu clock runs in sleep");

  no_tick_gated_a: assert property (
    !$past(GATES.cpu) |-> !SYS_TICK) else $error("tick with cpu gated");

  flash_with_cpu_a: assert property (
    GATES.flash == GATES.cpu) else $error("flash gate differs from cpu");

  asy_in_save_a: assert property (
    go_sleep_s ##0 mode_q == clk_ctrl_pkg::SLP_PWR_SAVE |=> GATES.asy)
    else $error("async clock stopped in power-save");

  adc_quiet_a: assert property (
    go_sleep_s ##0 mode_q == clk_ctrl_pkg::SLP_ADC_NR
    |=> GATES.adc && !GATES.cpu && !GATES.io)
    else $error("noise reduction gating wrong");

  lp_decode_a: assert property (
    cksel_q[3] |-> src == clk_ctrl_pkg::SRC_LP_XTAL)
    else $error("low power crystal not decoded");

  div8_tick_a: assert property (
    SYS_TICK && $past(div8_q) == `FUSE_PROG |-> $past(div_q) == `DIV8_LAST)
    else $error("divided tick off the eighth edge");

  timeout_next_a: assert property (
    state_q == clk_ctrl_pkg::ST_TIMEOUT && rst_src_ok |=>
    state_q inside {clk_ctrl_pkg::ST_TIMEOUT, clk_ctrl_pkg::ST_STARTUP})
    else $error("time-out left to wrong state");

  wake_skips_tout_a: assert property (
    deep_wake_s ##1 rst_src_ok |-> state_q != clk_ctrl_pkg::ST_TIMEOUT)
    else $error("wake ran the time-out");

  reset_gated_a: assert property (
    !INT_RESET_N |-> !GATES.cpu && !GATES.io)
    else $error("clocks run during internal reset");

  ack_single_a: assert property (
    WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");

endmodule // clock_source_select_startup

// ---- osc_src.sv ----
// Behavioural model of the watchdog and selected oscillators
`timescale 1ns/1ps
module osc_src #(
  parameter int WDT_HALF = 4,
  parameter int SEL_HALF = 3
) (
  input wire logic clk,
  output logic wdt_osc,
  output logic sel_osc
);
  logic w_q = 1'b0;
  logic s_q = 1'b0;
  int wcnt = 0;
  int scnt = 0;

  // Half periods of three core cycles or more, so the pin filter sees
  // every level; both run free, as real oscillators do
  always @(posedge clk) begin
    wcnt <= (wcnt == WDT_HALF - 1) ? 0 : wcnt + 1;
    scnt <= (scnt == SEL_HALF - 1) ? 0 : scnt + 1;
    if (wcnt == WDT_HALF - 1) w_q <= ~w_q;
    if (scnt == SEL_HALF - 1) s_q <= ~s_q;
  end

  assign wdt_osc = w_q;
  assign sel_osc = s_q;
endmodule // osc_src

// ---- tb.sv ----
// Self-checking bench for clock source select and start-up sequencing
`timescale 1ns/1ps
`define CHK(nm, e, g) chk(nm, 32'(e), 32'(g))
module tb;
  localparam int TL = 16;
  localparam int SU16 = 20;
  // Oscillator periods in core cycles, set by the model's half periods
  localparam int WP = 8;
  localparam int OP = 6;
  localparam logic [3:0] TC [7] = '{4'hE, 4'hF, 4'h8, 4'h2, 4'h0, 4'h4, 4'h3};
  localparam logic [1:0] TS [7] = '{2'h1, 2'h1, 2'h0, 2'h1, 2'h0, 2'h2, 2'h0};
  localparam logic TD [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  // time-out and start-up counts per type; zero time-outs rely on RST_SRC_N
  localparam int TT [7] = '{TL, 0, 512, 512, 0, TL, TL};
  localparam int TU [7] = '{258, SU16, 258, 6, 6, 1024, SU16};
  localparam logic [2:0] TR [7] = '{3'h0, 3'h0, 3'h0, 3'h2, 3'h3, 3'h1, 3'h4};
  localparam logic [5:0] SG [6] = '{6'h16, 6'h06, 6'h00, 6'h02, 6'h00, 6'h02};

  logic clk, rst_n, cyc, stb, we, ack, rst_src_n, wdt, osc;
  logic ext, two_wire_interface, int_rst_n, tick, async_int, twi_wake, fdiv8;
  logic [7:0] adr;
  logic [31:0] wdat, dat_o, q, st;
  logic [3:0] fcksel;
  logic [3:0] sel;
  logic [3:0] sel_v = 4'hF;
  logic [1:0] fsut;
  clk_ctrl_pkg::gates_t gates;
  int n_mismatch = 0;
  int n_checks = 0;
  int i, m, n;
  logic bad;

  clock_source_select_startup #(.TOUT_LONG_CYC(16'(TL)),
    .SU_16K_CYC(16'(SU16)), .PLL_LOCK_CYC(16'h0004)) dut (
    .CORE_CLK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .FUSE_CKSEL(fcksel),
    .FUSE_SUT(fsut), .FUSE_DIV8(fdiv8), .RST_SRC_N(rst_src_n),
    .WDT_OSC(wdt), .SEL_OSC(osc), .EXT_INT(ext), .TWI_ADDR_MATCH(two_wire_interface),
    .GATES(gates), .INT_RESET_N(int_rst_n), .SYS_TICK(tick),
    .ASYNC_INT(async_int), .TWI_WAKE(twi_wake));

  osc_src osc_i (.clk(clk), .wdt_osc(wdt), .sel_osc(osc));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] ev, logic [31:0] gv);
    n_checks++;
    if (ev !== gv) begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", nm, ev, gv);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= sel_v;
    wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) begin
      chk("bus ack", 1'b1, ack);
      conclude();
    end
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask

  // Near values pass as exact: filter latency and oscillator phase
  task automatic near(string nm, int ev, int gv, int tol);
    if (gv >= ev - tol && gv <= ev + tol) gv = ev;
    chk(nm, ev, gv);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic boot(input int c);
    @(posedge clk);
    rst_src_n <= 1'b0;
    fcksel <= TC[c];
    fsut <= TS[c];
    fdiv8 <= TD[c];
    repeat (12) @(posedge clk);
    `CHK("held reset", 1'b0, int_rst_n);
    rst_src_n <= 1'b1;
    n = 0;
    bad = 1'b0;
    while (int_rst_n !== 1'b1 && n < 12000) begin
      @(posedge clk);
      n++;
      if (int_rst_n === 1'b0 && gates !== 6'h00) bad = 1'b1;
    end
    `CHK("gates in reset", 1'b0, bad);
    near("boot cycles", TT[c] * WP + TU[c] * OP, n, 24);
    if (n >= 12000) conclude();
    wb(1'b0, 8'h04, 32'h0, q);
    `CHK("source", TR[c], q[18:16]);
    `CHK("fuses", {TD[c], TS[c], TC[c]}, q[6:0]);
    `CHK("multiplier", 8'h18, q[15:8]);
    `CHK("run gates", 6'h3E, gates);
    n = 0;
    repeat (480) begin
      @(posedge clk);
      if (tick === 1'b1) n++;
    end
    near("ticks", TD[c] ? 80 : 10, n, 1);
    $display("boot case %0d done", c);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    rst_src_n = 1'b0;
    ext = 1'b0;
    two_wire_interface = 1'b0;
    fcksel = 4'hE;
    fsut = 2'h1;
    fdiv8 = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 6; i >= 0; i--) boot(i);

    wb(1'b1, 8'h00, 32'h0000_0A02, q);
    wb(1'b0, 8'h00, 32'h0, q);
    `CHK("ctrl readback", 32'h0000_0A02, q);
    sel_v = 4'h2;
    wb(1'b1, 8'h00, 32'h0000_0503, q);
    sel_v = 4'hF;
    wb(1'b0, 8'h00, 32'h0, q);
    `CHK("byte select", 32'h0000_0502, q);
    wb(1'b0, 8'h08, 32'h0, q);
    `CHK("gates reg", 6'h3E, q);
    wb(1'b0, 8'h04, 32'h0, st);
    `CHK("run state", 3'h3, st[22:20]);
    wb(1'b1, 8'h04, 32'hFFFF_FFFF, q);
    wb(1'b1, 8'h0C, 32'hFFFF_FFFF, q);
    wb(1'b0, 8'h0C, 32'h0, q);
    `CHK("unmapped read", 32'h0, q);
    wb(1'b0, 8'h04, 32'h0, q);
    `CHK("status kept", st, q);
    $display("register test done");

    for (m = 0; m < 6; m++) begin
      wb(1'b1, 8'h00, {28'h0, 1'b1, 3'(m)}, q);
      repeat (6) @(posedge clk);
      `CHK("sleep gates", SG[m], gates);
      if (m % 2 == 1) two_wire_interface <= 1'b1;
      else ext <= 1'b1;
      n = 0;
      bad = 1'b0;
      while (gates.cpu !== 1'b1 && n < 3000) begin
        @(posedge clk);
        n++;
        if (int_rst_n === 1'b0) bad = 1'b1;
      end
      `CHK("wake level", 1'b1, (m % 2 == 1) ? twi_wake : async_int);
      `CHK("wake reset", (m == 2 || m == 3), bad);
      near("wake cycles", (m == 2 || m == 3) ? 258 * OP : 0, n, 24);
      if (n >= 3000) conclude();
      ext <= 1'b0;
      two_wire_interface <= 1'b0;
      repeat (12) @(posedge clk);
      $display("sleep mode %0d done", m);
    end

    // Prescaler value only stored; software picks it for a 2 MHz input
    wb(1'b1, 8'h00, 32'h0000_0310, q);
    n = 0;
    while (gates.usb !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    `CHK("usb gate", 6'h3F, gates);
    if (n >= 200) conclude();
    wb(1'b0, 8'h04, 32'h0, q);
    `CHK("pll lock", 1'b1, q[7]);
    $display("pll test done");
    conclude();
  end

  initial begin
    repeat (90000) @(posedge clk);
    chk("run length", 1'b0, 1'b1);
    conclude();
  end
endmodule // tb
